//--- cstd_card_supply_timer_and_detect.sv
// card supply stable timer, off delay timer and card detect logic
// assumes one 10 MHz clock, a 1 kHz keypad tick on the same clock,
// and asynchronous pins (detect switch, supply good, ready)
`timescale 1ns/1ps
module cstd_card_supply_timer_and_detect
  import cstd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [17:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // pins and ticks
  input wire logic card_detect_pin,
  input wire logic supply_good_flag,
  input wire logic ready_in,
  input wire logic keypad_tick,
  input wire logic core_fault,
  // pad controls and supply
  output logic pullup_enable_n,
  output logic pulldown_enable,
  output logic [1:0] supply_select,
  output logic deactivate,
  output logic irq
);
  import cstd_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] timing_q; // off count high nibble, check count low
  logic [7:0] detect_q; // detect control, bit 0 unused here
  logic [1:0] sel_q; // supply select bits
  logic rdy_st_q; // ready status flag
  logic power_down_flag_q; // power down flag
  logic [1:0] status_q; // sticky events
  logic [1:0] mask_q; // event mask
  logic present_q; // card present
  logic ack_q; // one cycle of wait state per access
  cstd_state_e state_q;
  logic [3:0] cnt_q; // slow period counter
  logic [8:0] div_q; // divider toward 32768 Hz
  logic slow_tick;
  logic [6:0] deb_q; // debounce ms counter
  logic [1:0] det_sync_q, good_sync_q, rdy_sync_q;
  logic det_s, good_s, rdy_s;
  logic raw_present;
  logic ev_card, ev_fail;
  logic sel_zero_wr, sel_set_wr, hw_clear;
  logic acc, wr_ok, rd_ok;

  ////////////////////////////////////////////////////////////////////
  // bus handshake: every access waits exactly one cycle
  assign acc = (read | write) & ~ack_q;
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_ok = write & ack_q & byteenable[0];
  assign rd_ok = read & ack_q;

  // acknowledge flop toggles the wait state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for the pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      det_sync_q <= 2'b00;
      good_sync_q <= 2'b00;
      rdy_sync_q <= 2'b00;
    end else begin
      det_sync_q <= {det_sync_q[0], card_detect_pin};
      good_sync_q <= {good_sync_q[0], supply_good_flag};
      rdy_sync_q <= {rdy_sync_q[0], ready_in};
    end
  end
  assign det_s = det_sync_q[1];
  assign good_s = good_sync_q[1];
  assign rdy_s = rdy_sync_q[1];

  ////////////////////////////////////////////////////////////////////
  // 32768 Hz enable from the system clock; period rounds down
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_q <= 9'h000;
    end else if (slow_tick) begin
      div_q <= 9'h000;
    end else begin
      div_q <= div_q + 9'h001;
    end
  end
  assign slow_tick = (div_q == CSTD_SLOW_DIV - 9'h001);

  ////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timing_q <= CSTD_TIMING_RST;
      detect_q <= CSTD_DETECT_RST;
      rdy_st_q <= 1'b0;
      power_down_flag_q <= 1'b0;
      mask_q <= 2'b00;
    end else if (wr_ok) begin
      if (address == CSTD_ADDR_TIMING) begin
        timing_q <= writedata[7:0];
      end else if (address == CSTD_ADDR_DETECT) begin
        // presence bit is read-only
        detect_q <= {writedata[7:1], 1'b0};
      end else if (address == CSTD_ADDR_SUPPLY) begin
        rdy_st_q <= writedata[CSTD_B_RDY_ST];
        power_down_flag_q <= writedata[CSTD_B_POWER_DOWN_FLAG];
      end else if (address == CSTD_ADDR_MASK) begin
        mask_q <= writedata[1:0];
      end
    end
  end

  // software writes to the select bits
  assign sel_set_wr = wr_ok && (address == CSTD_ADDR_SUPPLY)
                      && (writedata[1:0] != 2'b00);
  assign sel_zero_wr = wr_ok && (address == CSTD_ADDR_SUPPLY)
                       && (writedata[1:0] == 2'b00);

  ////////////////////////////////////////////////////////////////////
  // supply sequencer; emergency paths bypass the off delay
  assign hw_clear = ev_fail | core_fault | ev_card;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= CSTD_IDLE;
      sel_q <= 2'b00;
      cnt_q <= 4'h0;
    end else begin
      case (state_q)
        CSTD_IDLE: begin
          if (sel_set_wr) begin
            sel_q <= writedata[1:0];
            cnt_q <= 4'h0;
            // zero count means wait for ready instead of timing out
            state_q <= (timing_q[3:0] == 4'h0) ? CSTD_WAIT_RDY : CSTD_CHECK;
          end
        end
        CSTD_CHECK, CSTD_WAIT_RDY, CSTD_ON: begin
          if (hw_clear && state_q != CSTD_IDLE && !(state_q == CSTD_CHECK
              && !ev_fail && !core_fault && !ev_card)) begin
            sel_q <= 2'b00;
            state_q <= CSTD_DEACT;
          end else if (sel_zero_wr) begin
            cnt_q <= 4'h0;
            // zero off count goes straight to deactivation
            state_q <= (timing_q[7:4] == 4'h0) ? CSTD_DEACT : CSTD_OFF_DLY;
            sel_q <= 2'b00;
          end else if (state_q == CSTD_CHECK) begin
            if (slow_tick) begin
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q + 4'h1 == timing_q[3:0] && good_s) begin
                state_q <= CSTD_ON;
              end
            end
          end else if (state_q == CSTD_WAIT_RDY) begin
            if (rdy_st_q && rdy_s) begin
              state_q <= CSTD_ON;
            end
          end
        end
        CSTD_OFF_DLY: begin
          if (core_fault || ev_card) begin
            state_q <= CSTD_DEACT;
          end else if (slow_tick) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q + 4'h1 == timing_q[7:4]) begin
              state_q <= CSTD_DEACT;
            end
          end
        end
        CSTD_DEACT: begin
          state_q <= CSTD_IDLE;
        end
        default: begin
          state_q <= CSTD_IDLE;
        end
      endcase
    end
  end
  // check expiry with supply not good
  assign ev_fail = (state_q == CSTD_CHECK) && slow_tick
                   && (cnt_q + 4'h1 == timing_q[3:0]) && !good_s;

  ////////////////////////////////////////////////////////////////////
  // card detect: polarity, enable and debounce
  // runs on the system clock only, never on the card logic clock
  assign raw_present = detect_q[CSTD_B_DET_EN]
                       & (detect_q[CSTD_B_POL] ? det_s : ~det_s);

  // presence drops at once; rises after 64 stable ticks when debounced
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      present_q <= 1'b0;
      deb_q <= 7'h00;
    end else if (!raw_present) begin
      present_q <= 1'b0;
      deb_q <= 7'h00;
    end else if (!detect_q[CSTD_B_DEBOUNCE] || power_down_flag_q) begin
      present_q <= 1'b1;
    end else if (keypad_tick && !present_q) begin
      deb_q <= deb_q + 7'h01;
      if (deb_q + 7'h01 == CSTD_DEB_TICKS) begin
        present_q <= 1'b1;
      end
    end
  end
  // any change of presence is a card event
  logic present_d1_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      present_d1_q <= 1'b0;
    end else begin
      present_d1_q <= present_q;
    end
  end
  assign ev_card = present_d1_q ^ present_q;

  ////////////////////////////////////////////////////////////////////
  // sticky status; a read clears it but a new event wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_q <= 2'b00;
    end else begin
      status_q <= ((rd_ok && address == CSTD_ADDR_STATUS) ? 2'b00 : status_q)
                  | {core_fault, ev_card | ev_fail};
    end
  end
  assign irq = |(status_q & mask_q);

  ////////////////////////////////////////////////////////////////////
  // read data registered on the wait cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack_q) begin
      if (address == CSTD_ADDR_TIMING) begin
        readdata <= {24'h000000, timing_q};
      end else if (address == CSTD_ADDR_DETECT) begin
        readdata <= {24'h000000, detect_q[7:1], present_q};
      end else if (address == CSTD_ADDR_SUPPLY) begin
        readdata <= {26'h0000000, state_q == CSTD_ON, state_q == CSTD_DEACT,
                     power_down_flag_q, rdy_st_q, sel_q};
      end else if (address == CSTD_ADDR_STATUS) begin
        readdata <= {30'h00000000, status_q};
      end else if (address == CSTD_ADDR_MASK) begin
        readdata <= {30'h00000000, mask_q};
      end else begin
        readdata <= 32'h0000_0000; // unmapped reads zero
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pad and supply outputs
  assign pullup_enable_n = detect_q[CSTD_B_PU_N];
  assign pulldown_enable = detect_q[CSTD_B_PD];
  assign supply_select = sel_q;
  assign deactivate = (state_q == CSTD_DEACT);
endmodule

//--- cstd_pkg.sv
// constants for the card supply timer and card detect block
// assumes a 10 MHz system clock and an Avalon-MM slave with 32-bit data
package cstd_pkg;
  // register byte addresses (word aligned, index times four)
  localparam logic [15:0] CSTD_IDX_TIMING = 16'hFE04;
  localparam logic [15:0] CSTD_IDX_DETECT = 16'hFE05;
  localparam logic [15:0] CSTD_IDX_SUPPLY = 16'hFE00;
  localparam logic [15:0] CSTD_IDX_STATUS = 16'hFE01;
  localparam logic [15:0] CSTD_IDX_MASK = 16'hFE02;
  localparam logic [17:0] CSTD_ADDR_TIMING = {CSTD_IDX_TIMING, 2'b00};
  localparam logic [17:0] CSTD_ADDR_DETECT = {CSTD_IDX_DETECT, 2'b00};
  localparam logic [17:0] CSTD_ADDR_SUPPLY = {CSTD_IDX_SUPPLY, 2'b00};
  localparam logic [17:0] CSTD_ADDR_STATUS = {CSTD_IDX_STATUS, 2'b00};
  localparam logic [17:0] CSTD_ADDR_MASK = {CSTD_IDX_MASK, 2'b00};
  // reset values
  localparam logic [7:0] CSTD_TIMING_RST = 8'h0F;
  localparam logic [7:0] CSTD_DETECT_RST = 8'h00;
  // field positions of the detect control register
  localparam int CSTD_B_DEBOUNCE = 7;
  localparam int CSTD_B_DET_EN = 6;
  localparam int CSTD_B_POL = 3;
  localparam int CSTD_B_PU_N = 2;
  localparam int CSTD_B_PD = 1;
  localparam int CSTD_B_PRESENT = 0;
  // field positions of the supply control register
  localparam int CSTD_B_SEL_LO = 0;
  localparam int CSTD_B_SEL_HI = 1;
  localparam int CSTD_B_RDY_ST = 2;
  localparam int CSTD_B_POWER_DOWN_FLAG = 3;
  localparam int CSTD_B_DEACT = 4;
  localparam int CSTD_B_ACTIVE = 5;
  // status bits
  localparam int CSTD_EV_CARD = 0;
  localparam int CSTD_EV_FAULT = 1;
  // timing
  localparam longint CSTD_CLK_HZ = 10000000;
  localparam longint CSTD_SLOW_HZ = 32768;
  localparam logic [8:0] CSTD_SLOW_DIV = 9'(CSTD_CLK_HZ / CSTD_SLOW_HZ); // rounds down
  localparam int CSTD_DEB_MS = 64;
  localparam logic [6:0] CSTD_DEB_TICKS = 7'(CSTD_DEB_MS);
  // supply sequencing states
  typedef enum logic [2:0] {
    CSTD_IDLE = 3'b000,
    CSTD_CHECK = 3'b001,
    CSTD_WAIT_RDY = 3'b010,
    CSTD_ON = 3'b011,
    CSTD_OFF_DLY = 3'b100,
    CSTD_DEACT = 3'b101
  } cstd_state_e;
endpackage

//--- cstd_card_supply_timer_and_detect_chk.sv
// checker for the card supply timer and card detect block
// assumes one clock domain and the block's own port names
`timescale 1ns/1ps
module cstd_card_supply_timer_and_detect_chk
  import cstd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register bus
  input wire logic [17:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  // supply and pads
  input wire logic core_fault,
  input wire logic pullup_enable_n,
  input wire logic pulldown_enable,
  input wire logic [1:0] supply_select,
  input wire logic deactivate,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // accepted writes to the detect and supply registers
  logic wr_det;
  logic wr_sup;
  assign wr_det = write && !waitrequest && byteenable[0] && address == CSTD_ADDR_DETECT;
  assign wr_sup = write && !waitrequest && byteenable[0] && address == CSTD_ADDR_SUPPLY;
  sequence s_one_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  sequence s_off;
    deactivate ##[0:1] supply_select == 2'b00;
  endsequence
  property p_wait; $rose(read) || $rose(write) |-> s_one_wait; endproperty
  property p_fault; $rose(core_fault) && supply_select != 2'b00 |-> ##[1:4] s_off; endproperty
  property p_pulse; deactivate |=> !deactivate; endproperty
  property p_deact_sel; deactivate |-> s_off; endproperty
  property p_pads;
    wr_det |=> pullup_enable_n == $past(writedata[CSTD_B_PU_N])
      && pulldown_enable == $past(writedata[CSTD_B_PD]);
  endproperty
  property p_act;
    wr_sup && supply_select == 2'b00 && writedata[1:0] != 2'b00 && !core_fault && !deactivate
      |=> supply_select == $past(writedata[1:0]);
  endproperty
  property p_only_sw; $rose(|supply_select) |-> $past(wr_sup); endproperty
  property p_rst; $fell(rst) |-> supply_select == 2'b00 && !irq && !deactivate; endproperty
  a_wait: assert property (p_wait) else $error("access without one wait state");
  a_fault: assert property (p_fault) else $error("fault did not deactivate");
  a_pulse: assert property (p_pulse) else $error("deactivate longer than a cycle");
  a_deact_sel: assert property (p_deact_sel) else $error("selects kept at deactivate");
  a_pads: assert property (p_pads) else $error("pad controls differ from register");
  a_act: assert property (p_act) else $error("activation select not taken");
  a_only_sw: assert property (p_only_sw) else $error("selects rose without write");
  a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule
bind cstd_card_supply_timer_and_detect cstd_card_supply_timer_and_detect_chk u_chk (
  .clock, .rst, .address, .read, .write, .writedata, .byteenable, .waitrequest,
  .core_fault, .pullup_enable_n, .pulldown_enable, .supply_select, .deactivate, .irq);

//--- cstd_card_side.sv
// model of the connector detect switch and the card supply
// assumes the bench sets the controls at clock edges, rising or falling
`timescale 1ns/1ps
module cstd_card_side (
  // clock and bench controls
  input wire logic clock,
  input wire logic inserted,
  input wire logic contact_high,
  input wire logic good_cmd,
  // from the block
  input wire logic pullup_enable_n,
  input wire logic pulldown_enable,
  input wire logic [1:0] supply_select,
  // to the block
  output logic card_detect_pin,
  output logic supply_good_flag,
  output logic ready_in
);
  logic [4:0] ramp_q = 5'h00; // clocks since the supply was selected
  logic float_q = 1'b0; // an undriven pin wanders, so it toggles here
  // supply ramps for a while before it reports good
  always_ff @(posedge clock) begin
    float_q <= !float_q;
    ramp_q <= (supply_select == 2'b00) ? 5'h00 : ramp_q + {4'h0, ramp_q != 5'h1F};
  end
  // open switch leaves the pin to the pad pulls
  assign card_detect_pin = inserted ? contact_high :
    !pullup_enable_n ? 1'b1 : pulldown_enable ? 1'b0 : float_q;
  assign supply_good_flag = good_cmd && ramp_q > 5'h14;
  assign ready_in = supply_good_flag;
endmodule

//--- cstd_card_supply_timer_and_detect_tb.sv
// self-checking bench for the card supply timer and card detect block
// assumes the package, checker and card side model are compiled first
`timescale 1ns/1ps
module cstd_card_supply_timer_and_detect_tb;
  import cstd_pkg::*;
  logic clock = 0, rst = 1, read = 0, write = 0, keypad_tick = 0, core_fault = 0;
  logic [17:0] address = 18'h00000;
  logic [31:0] writedata = 32'h0, readdata, rdat;
  logic [3:0] byteenable = 4'hF, tick_q = 4'h0;
  logic waitrequest, card_detect_pin, supply_good_flag, ready_in, pullup_enable_n;
  logic pulldown_enable, deactivate, irq, inserted = 0, contact_high = 0, good_cmd = 1;
  logic [1:0] supply_select;
  int mismatches = 0, n_tests = 0, n;
  cstd_card_supply_timer_and_detect dut (.clock, .rst, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .card_detect_pin, .supply_good_flag, .ready_in,
    .keypad_tick, .core_fault, .pullup_enable_n, .pulldown_enable, .supply_select,
    .deactivate, .irq);
  cstd_card_side card (.clock, .inserted, .contact_high, .good_cmd, .pullup_enable_n,
    .pulldown_enable, .supply_select, .card_detect_pin, .supply_good_flag, .ready_in);
  initial forever #50 clock = ~clock;
  // keypad tick sped up to one per 16 clocks so the debounce fits the run
  always @(posedge clock) begin
    tick_q <= tick_q + 4'h1;
    keypad_tick <= (tick_q == 4'hF);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus access; request held until the rising edge that sees waitrequest low
  // read data is taken at that same edge, then the request is released
  task automatic bus(input logic r, input logic [17:0] a, input logic [31:0] d);
    @(posedge clock);
    read <= r;
    write <= !r;
    address <= a;
    writedata <= d;
    do @(posedge clock); while (waitrequest);
    rdat = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic bit_is(input logic b, e);
    chk({7'h0, b}, {7'h0, e});
  endtask
  // cycles until the deactivation pulse must lie within lo..hi
  task automatic to_deact(input int lo, hi);
    n = 0;
    while (!deactivate && n < 6000) begin
      @(negedge clock);
      n++;
    end
    bit_is(n >= lo && n <= hi, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    bus(1, CSTD_ADDR_TIMING, 0); chk(rdat[7:0], CSTD_TIMING_RST);
    bus(1, CSTD_ADDR_DETECT, 0); chk(rdat[7:0], CSTD_DETECT_RST);
    bus(0, 18'h00010, 32'hFF);
    bus(1, 18'h00010, 0); chk(rdat[7:0], 8'h00);
    bus(0, CSTD_ADDR_MASK, 32'h03);
  endtask
  // both polarities: enable gating, presence, removal and events
  task automatic t_detect;
    logic [7:0] v;
    for (int p = 1; p >= 0; p--) begin
      v = p ? 8'h0E : 8'h00;
      bus(0, CSTD_ADDR_DETECT, {24'h0, v});
      @(negedge clock);
      chk({6'h0, pullup_enable_n, pulldown_enable}, p ? 8'h03 : 8'h00);
      inserted <= 1'b1;
      contact_high <= p[0];
      repeat (10) @(negedge clock);
      bus(1, CSTD_ADDR_DETECT, 0); bit_is(rdat[0], 1'b0);
      bus(0, CSTD_ADDR_DETECT, {24'h0, v | 8'h40});
      repeat (10) @(negedge clock);
      bus(1, CSTD_ADDR_DETECT, 0); bit_is(rdat[0], 1'b1);
      bit_is(irq, 1'b1);
      bus(1, CSTD_ADDR_STATUS, 0); bit_is(rdat[0], 1'b1);
      inserted <= 1'b0;
      // the pin still passes the two synchroniser flops first
      repeat (5) @(negedge clock);
      bus(1, CSTD_ADDR_DETECT, 0); bit_is(rdat[0], 1'b0);
      bus(1, CSTD_ADDR_STATUS, 0); bit_is(rdat[0], 1'b1);
      @(negedge clock); bit_is(irq, 1'b0);
      bus(0, CSTD_ADDR_DETECT, {24'h0, v});
    end
  endtask
  task automatic t_debounce;
    bus(0, CSTD_ADDR_DETECT, 32'h8E);
    bus(0, CSTD_ADDR_DETECT, 32'hCE);
    inserted <= 1'b1;
    contact_high <= 1'b1;
    repeat (512) @(negedge clock);
    bus(1, CSTD_ADDR_DETECT, 0); bit_is(rdat[0], 1'b0);
    repeat (640) @(negedge clock);
    bus(1, CSTD_ADDR_DETECT, 0); bit_is(rdat[0], 1'b1);
    inserted <= 1'b0;
    repeat (5) @(negedge clock);
    bus(1, CSTD_ADDR_DETECT, 0); bit_is(rdat[0], 1'b0);
    bus(0, CSTD_ADDR_SUPPLY, 32'h08);
    inserted <= 1'b1;
    repeat (10) @(negedge clock);
    bus(1, CSTD_ADDR_DETECT, 0); bit_is(rdat[0], 1'b1);
    inserted <= 1'b0;
    bus(0, CSTD_ADDR_SUPPLY, 32'h00);
    bus(1, CSTD_ADDR_STATUS, 0);
  endtask
  // check pass and fail, off delays, wait for ready, fault
  task automatic t_supply;
    bus(0, CSTD_ADDR_TIMING, 32'h02);
    bus(0, CSTD_ADDR_SUPPLY, 32'h01);
    repeat (1000) @(negedge clock);
    chk({6'h0, supply_select}, 8'h01);
    bus(0, CSTD_ADDR_SUPPLY, 32'h00); to_deact(0, 10);
    good_cmd <= 1'b0;
    bus(0, CSTD_ADDR_SUPPLY, 32'h01); to_deact(300, 625);
    @(negedge clock); bit_is(irq, 1'b1);
    chk({6'h0, supply_select}, 8'h00);
    bus(1, CSTD_ADDR_STATUS, 0); bit_is(rdat[0], 1'b1);
    good_cmd <= 1'b1;
    bus(0, CSTD_ADDR_TIMING, 32'h31);
    bus(0, CSTD_ADDR_SUPPLY, 32'h02);
    repeat (400) @(negedge clock);
    bus(0, CSTD_ADDR_SUPPLY, 32'h00); to_deact(600, 930);
    bus(0, CSTD_ADDR_TIMING, 32'hF0);
    bus(0, CSTD_ADDR_SUPPLY, 32'h01);
    repeat (400) @(negedge clock);
    chk({6'h0, supply_select}, 8'h01);
    bus(1, CSTD_ADDR_SUPPLY, 0); bit_is(rdat[CSTD_B_ACTIVE], 1'b0);
    bus(0, CSTD_ADDR_SUPPLY, 32'h05);
    repeat (5) @(negedge clock);
    bus(1, CSTD_ADDR_SUPPLY, 0); bit_is(rdat[CSTD_B_ACTIVE], 1'b1);
    core_fault <= 1'b1; to_deact(0, 10);
    @(posedge clock);
    core_fault <= 1'b0;
    bus(1, CSTD_ADDR_STATUS, 0); bit_is(rdat[CSTD_EV_FAULT], 1'b1);
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_detect;
    t_debounce;
    t_supply;
    report_and_stop;
  end
  // watchdog well beyond the expected run of some five thousand cycles
  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    report_and_stop;
  end
endmodule
